// [design/bitmr_regs.svh]
`ifndef BITMR_REGS_SVH
`define BITMR_REGS_SVH

// ==========================================================================
// Register offsets
// ==========================================================================
`define BITMR_ADDR_COUNT_CTRL 8'hec // Read: interval count, write: control
`define BITMR_ADDR_STATUS     8'hed // Sticky event flags, write one to clear
`define BITMR_ADDR_MASK       8'hee // Interrupt enables, same layout as status
`define BITMR_ADDR_WATCHDOG   8'hef // Write: limit and restart, read: count

// ==========================================================================
// Control field positions
// ==========================================================================
`define BITMR_CTL_WAKE_BIT    6 // Wake-up timer enable
`define BITMR_CTL_RC_WATCHDOG_MODE_ENABLE_BIT   5 // Internal RC watchdog mode enable
`define BITMR_CTL_WDSEL_BIT   4 // Watchdog select (1) or plain timer (0)
`define BITMR_CTL_CLEAR_BIT   3 // Clear command, self clearing
`define BITMR_CTL_SEL_MSB     2 // Clock select, top bit
`define BITMR_CTL_SEL_LSB     0 // Clock select, bottom bit

// ==========================================================================
// Status and mask bit positions
// ==========================================================================
`define BITMR_STS_OVERFLOW    0 // Interval counter wrapped
`define BITMR_STS_WDT_MATCH   1 // Seven-bit timer reached its limit

// ==========================================================================
// Reset values
// ==========================================================================
`define BITMR_CTL_RESET       8'h17 // Wake 0, RC 0, select 1, clear 0, sel 111
`define BITMR_MASK_RESET      2'h0  // All interrupts masked
`define BITMR_WDT_LIMIT_RESET 7'h7f // Longest watchdog period

// ==========================================================================
// Timing counts
// ==========================================================================
`define BITMR_MACHINE_CYCLE_CLKS 2  // One machine cycle is two oscillator clocks
`define BITMR_PRESCALE_BASE      11'h008 // Divide ratio of select code zero
`define BITMR_WAKE_TAP_MASK      11'h7ff // Divide by 2048 tap

`endif

// [design/bitmr_pkg.sv]
package bitmr_pkg;

  // ========================================================================
  // Power modes, one-hot
  // ========================================================================
  typedef enum logic [3:0] {
    BITMR_RUN        = 4'h1, // Normal operation
    BITMR_WAKE_TIMER = 4'h2, // Stopped, only the long prescaler tap runs
    BITMR_RC_WDT     = 4'h4, // Stopped, interval counter and watchdog run
    BITMR_STOP       = 4'h8  // Stopped, counter halted, long prescaler tap still runs
  } bitmr_mode_type;

  typedef logic [7:0] bitmr_byte_type;   // Bus data width
  typedef logic [2:0] bitmr_select_type; // Clock select code

endpackage

// [design/bitmr_prescaler.sv]
`timescale 1ns/1ps
`include "bitmr_regs.svh"

// Free-running oscillator divider with a selectable tap and a fixed long tap
module bitmr_prescaler
  import bitmr_pkg::*;
(
  input  wire logic                       clk_in,
  input  wire logic                       reset_in,
  input  wire bitmr_pkg::bitmr_select_type sel_in,
  output logic                            tick_out,
  output logic                            wake_tick_out
);

  // ========================================================================
  // State
  // ========================================================================
  typedef struct packed {
    logic [10:0] div;  // Divider count
    logic        tick; // Selected tap pulse
    logic        wake; // Divide by 2048 pulse
  } bitmr_pre_state_type;

  bitmr_pre_state_type state_ff;     // Registered state
  bitmr_pre_state_type nxt_state;    // Next state

  // Tap mask: all ones across the low bits of the chosen ratio
  function automatic logic [10:0] tap_mask(input bitmr_select_type sel);
    tap_mask = (`BITMR_PRESCALE_BASE << sel) - 11'h001;
  endfunction

  // ========================================================================
  // Next state
  // ========================================================================
  always_comb begin
    nxt_state      = state_ff;
    nxt_state.div  = state_ff.div + 11'h001;
    // Doubling ratio per code, 8 up to 1024
    nxt_state.tick = ((state_ff.div & tap_mask(sel_in)) == tap_mask(sel_in));
    // Long tap keeps running in every mode
    nxt_state.wake = ((state_ff.div & `BITMR_WAKE_TAP_MASK) == `BITMR_WAKE_TAP_MASK);
  end

  // Register stage
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign tick_out      = state_ff.tick;
  assign wake_tick_out = state_ff.wake;

endmodule

// [design/bitmr_top.sv]
// Summary of operation
// - One free-running 8-bit counter, never halted by software
// - Advance per prescaler pulse, select 000 /8, 111 /1024
// - Wrap from ff to 00 sets overflow flag
// - Clear command zeroes count, counting resumes
// - Clear command drops itself after one machine cycle
// - Stop with wake enable enters wake-timer mode
// - Stop with RC enable and wake 0 keeps counter and watchdog running
// - Watchdog select picks watchdog or plain 7-bit timer
// - Shared address: read count, write control
// - Control resets to wake 0, RC 0, select 1, sel 111
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "bitmr_regs.svh"

module bitmr_top
  import bitmr_pkg::*;
(
  input  wire logic                      clk_in,                      // Oscillator clock
  input  wire logic                      reset_in,                    // Async reset, high
  input  wire logic [7:0]                addr_in,                     // Register address
  input  wire bitmr_pkg::bitmr_byte_type wdata_in,                    // Write data
  input  wire logic                      wr_in,                       // Write strobe
  input  wire logic                      rd_in,                       // Read strobe
  output bitmr_pkg::bitmr_byte_type      rdata_out,                   // Read data, next cycle
  input  wire logic                      stop_instruction_in,         // Stop executed, pulse
  input  wire logic                      wake_event_in,               // Wake from stop, pulse
  output logic                           irq_out,                     // Level interrupt
  output logic                           interval_overflow_out,       // Wrap pulse
  output logic                           watchdog_reset_out,          // Watchdog expiry pulse
  output logic                           wake_tick_out,               // Divide by 2048 pulse
  output bitmr_pkg::bitmr_mode_type      power_mode_out,              // Current power mode
  output logic                           wake_timer_enable_out,       // Control bit
  output logic                           rc_watchdog_mode_enable_out, // Control bit
  output logic                           watchdog_select_out          // Control bit
);

  // ========================================================================
  // State record
  // ========================================================================
  typedef struct packed {
    logic             wake_timer_enable;       // Wake mode on next stop
    logic             rc_watchdog_mode_enable; // RC watchdog mode on next stop
    logic             watchdog_select;         // Watchdog versus plain timer
    logic             interval_clear_command;  // Pending clear
    logic             clear_hold;              // Machine cycle countdown
    bitmr_select_type interval_clock_select;   // Prescaler tap
    logic [7:0]       interval_count_value;    // The interval counter
    logic [6:0]       wdt_count;               // Seven-bit timer count
    logic [6:0]       wdt_limit;               // Seven-bit timer limit
    logic [1:0]       status;                  // Sticky event flags
    logic [1:0]       mask;                    // Interrupt enables
    bitmr_byte_type   rdata;                   // Read data stage
    logic             irq;                     // Interrupt level
    logic             overflow_pulse;          // Wrap pulse out
    logic             wdt_reset;               // Watchdog reset pulse out
    logic             wake_tick;               // Long tap pulse out
    bitmr_mode_type   mode;                    // Power mode
  } bitmr_state_type;

  bitmr_state_type state_ff;     // Registered state
  bitmr_state_type nxt_state;    // Next state

  // Control reset image, sliced per field so no bits are dropped silently
  localparam bitmr_byte_type CTL_RESET_VALUE = `BITMR_CTL_RESET;

  // ========================================================================
  // Prescaler
  // ========================================================================
  logic pre_tick;                // Selected tap pulse
  logic pre_wake;                // Long tap pulse

  bitmr_prescaler i_bitmr_prescaler (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .sel_in        (state_ff.interval_clock_select),
    .tick_out      (pre_tick),
    .wake_tick_out (pre_wake)
  );

  // ========================================================================
  // Helpers
  // ========================================================================
  logic       wr_ctrl;           // Write to the shared address
  logic       wr_status;         // Write to status
  logic       wr_mask;           // Write to mask
  logic       wr_wdt;            // Write to watchdog register
  logic       counting;          // Counter runs in this mode
  logic       step;              // Counter advances this cycle
  logic       wrap;              // Counter wraps this cycle
  logic       wdt_match;         // Seven-bit timer reaches limit
  logic [1:0] set_flags;         // Hardware events this cycle
  logic [1:0] clr_flags;         // Software clears this cycle

  always_comb begin
    wr_ctrl   = wr_in && (addr_in == `BITMR_ADDR_COUNT_CTRL);
    wr_status = wr_in && (addr_in == `BITMR_ADDR_STATUS);
    wr_mask   = wr_in && (addr_in == `BITMR_ADDR_MASK);
    wr_wdt    = wr_in && (addr_in == `BITMR_ADDR_WATCHDOG);
    // Only the two stop modes without a running counter halt it
    counting  = (state_ff.mode == BITMR_RUN) || (state_ff.mode == BITMR_RC_WDT);
    step      = pre_tick && counting && !state_ff.interval_clear_command;
    wrap      = step && (state_ff.interval_count_value == 8'hff);
    // Seven-bit timer ticks on each wrap of the interval counter
    wdt_match = wrap && (state_ff.wdt_count == state_ff.wdt_limit);
    set_flags = 2'h0;
    set_flags[`BITMR_STS_OVERFLOW]  = wrap;
    set_flags[`BITMR_STS_WDT_MATCH] = wdt_match && !state_ff.watchdog_select;
    clr_flags = wr_status ? wdata_in[1:0] : 2'h0;
  end

  // ========================================================================
  // Next state
  // ========================================================================
  always_comb begin
    nxt_state                = state_ff;
    nxt_state.overflow_pulse = wrap;
    nxt_state.wake_tick      = pre_wake;
    nxt_state.wdt_reset      = 1'b0;

    // Control write; a read of this address never touches control
    if (wr_ctrl) begin
      nxt_state.wake_timer_enable       = wdata_in[`BITMR_CTL_WAKE_BIT];
      nxt_state.rc_watchdog_mode_enable = wdata_in[`BITMR_CTL_RC_WATCHDOG_MODE_ENABLE_BIT];
      nxt_state.watchdog_select         = wdata_in[`BITMR_CTL_WDSEL_BIT];
      nxt_state.interval_clock_select   =
        wdata_in[`BITMR_CTL_SEL_MSB:`BITMR_CTL_SEL_LSB];
    end

    // Clear command: set by a one, drops after one machine cycle
    if (wr_ctrl && wdata_in[`BITMR_CTL_CLEAR_BIT]) begin
      nxt_state.interval_clear_command = 1'b1;
      nxt_state.clear_hold             = 1'b1;
    end else if (state_ff.clear_hold) begin
      // Machine cycle is two clocks, so one extra clock of hold
      nxt_state.clear_hold = 1'b0;
    end else begin
      nxt_state.interval_clear_command = 1'b0;
    end

    // Interval counter; software has no way to halt it
    if (state_ff.interval_clear_command) begin
      nxt_state.interval_count_value = 8'h00;
    end else if (step) begin
      nxt_state.interval_count_value = state_ff.interval_count_value + 8'h01;
    end

    // Seven-bit timer or watchdog
    if (wr_wdt) begin
      // Restart on every write, also loads the limit
      nxt_state.wdt_limit = wdata_in[6:0];
      nxt_state.wdt_count = 7'h00;
    end else if (wdt_match) begin
      nxt_state.wdt_count = 7'h00;
      nxt_state.wdt_reset = state_ff.watchdog_select;
    end else if (wrap) begin
      nxt_state.wdt_count = state_ff.wdt_count + 7'h01;
    end

    // Sticky flags, a set in the clearing cycle wins
    nxt_state.status = (state_ff.status & ~clr_flags) | set_flags;
    if (wr_mask) begin
      nxt_state.mask = wdata_in[1:0];
    end
    nxt_state.irq = |(nxt_state.status & nxt_state.mask);

    // Power mode sequencing
    case (state_ff.mode)
      BITMR_RUN: begin
        if (stop_instruction_in) begin
          if (state_ff.wake_timer_enable) begin
            nxt_state.mode = BITMR_WAKE_TIMER;
          end else if (state_ff.rc_watchdog_mode_enable) begin
            nxt_state.mode = BITMR_RC_WDT;
          end else begin
            nxt_state.mode = BITMR_STOP;
          end
        end
      end
      BITMR_WAKE_TIMER, BITMR_STOP: begin
        // Counter frozen here; only an outside wake event restarts
        if (wake_event_in) begin
          nxt_state.mode = BITMR_RUN;
        end
      end
      BITMR_RC_WDT: begin
        // Watchdog expiry also ends the stop
        if (wake_event_in || (wdt_match && state_ff.watchdog_select)) begin
          nxt_state.mode = BITMR_RUN;
        end
      end
      default: begin
        nxt_state.mode = BITMR_RUN;
      end
    endcase

    // Read data, one cycle after the strobe; count, not control
    nxt_state.rdata = 8'h00;
    if (rd_in) begin
      case (addr_in)
        `BITMR_ADDR_COUNT_CTRL: begin
          nxt_state.rdata = state_ff.interval_count_value;
        end
        `BITMR_ADDR_STATUS: begin
          nxt_state.rdata = {6'h00, state_ff.status};
        end
        `BITMR_ADDR_MASK: begin
          nxt_state.rdata = {6'h00, state_ff.mask};
        end
        `BITMR_ADDR_WATCHDOG: begin
          nxt_state.rdata = {1'b0, state_ff.wdt_count};
        end
        default: begin
          nxt_state.rdata = 8'h00; // Unmapped reads as zero
        end
      endcase
    end
  end

  // ========================================================================
  // Register stage
  // ========================================================================
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_ff                         <= '0;
      state_ff.wake_timer_enable       <= CTL_RESET_VALUE[`BITMR_CTL_WAKE_BIT];
      state_ff.rc_watchdog_mode_enable <= CTL_RESET_VALUE[`BITMR_CTL_RC_WATCHDOG_MODE_ENABLE_BIT];
      state_ff.watchdog_select         <= CTL_RESET_VALUE[`BITMR_CTL_WDSEL_BIT];
      state_ff.interval_clock_select   <=
        CTL_RESET_VALUE[`BITMR_CTL_SEL_MSB:`BITMR_CTL_SEL_LSB];
      state_ff.wdt_limit               <= `BITMR_WDT_LIMIT_RESET;
      state_ff.mask                    <= `BITMR_MASK_RESET;
      state_ff.mode                    <= BITMR_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ========================================================================
  // Outputs, all from flip-flops
  // ========================================================================
  assign rdata_out                   = state_ff.rdata;
  assign irq_out                     = state_ff.irq;
  assign interval_overflow_out       = state_ff.overflow_pulse;
  assign watchdog_reset_out          = state_ff.wdt_reset;
  assign wake_tick_out               = state_ff.wake_tick;
  assign power_mode_out              = state_ff.mode;
  assign wake_timer_enable_out       = state_ff.wake_timer_enable;
  assign rc_watchdog_mode_enable_out = state_ff.rc_watchdog_mode_enable;
  assign watchdog_select_out         = state_ff.watchdog_select;

endmodule

// [testbench/bitmr_chk.sv]
`timescale 1ns/1ps
// ==================================================================
// Port checker for the interval timer
// ==================================================================
module bitmr_chk
  import bitmr_pkg::*;
(
  input wire logic                      clk_in,
  input wire logic                      reset_in,
  input wire logic [7:0]                addr_in,
  input wire bitmr_pkg::bitmr_byte_type wdata_in,
  input wire logic                      wr_in,
  input wire logic                      rd_in,
  input wire bitmr_pkg::bitmr_byte_type rdata_out,
  input wire logic                      stop_instruction_in,
  input wire logic                      interval_overflow_out,
  input wire logic                      watchdog_reset_out,
  input wire logic                      wake_tick_out,
  input wire bitmr_pkg::bitmr_mode_type power_mode_out,
  input wire logic                      wake_timer_enable_out,
  input wire logic                      rc_watchdog_mode_enable_out,
  input wire logic                      watchdog_select_out
);
  logic [11:0] gap_ff;  // Cycles since last long-tap pulse
  logic        seen_ff; // First pulse seen, phase after reset unknown

  // Gap counter, restarted by each long-tap pulse
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      gap_ff  <= 12'h000;
      seen_ff <= 1'b0;
    end else begin
      gap_ff  <= wake_tick_out ? 12'h000 : gap_ff + 12'h001;
      seen_ff <= seen_ff | wake_tick_out;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // Stop request taken while running
  sequence s_stop_in_run;
    stop_instruction_in && (power_mode_out == BITMR_RUN);
  endsequence
  // Held in wake-timer mode long enough for a late wrap pulse to drain
  sequence s_wake_hold;
    (power_mode_out == BITMR_WAKE_TIMER) [*3];
  endsequence

  chk_rdata_quiet: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  chk_ovf_single: assert property (interval_overflow_out |=> !interval_overflow_out [*8])
    else $error("overflow pulses too close together");
  chk_wake_period: assert property (wake_tick_out && seen_ff |-> gap_ff == 12'h7ff)
    else $error("long tap period is not 2048 clocks");
  chk_mode_onehot: assert property ($onehot(power_mode_out))
    else $error("power mode not one-hot");
  chk_stop_wake: assert property (
    s_stop_in_run and wake_timer_enable_out |=> power_mode_out == BITMR_WAKE_TIMER)
    else $error("stop with wake enable missed wake-timer mode");
  chk_stop_rc: assert property (
    s_stop_in_run and (!wake_timer_enable_out && rc_watchdog_mode_enable_out)
    |=> power_mode_out == BITMR_RC_WDT)
    else $error("stop with rc enable missed rc watchdog mode");
  chk_frozen_count: assert property (s_wake_hold |-> !interval_overflow_out)
    else $error("counter wrapped in wake-timer mode");
  chk_ctrl_bits: assert property (
    wr_in && addr_in == 8'hec |=> {wake_timer_enable_out, rc_watchdog_mode_enable_out,
    watchdog_select_out} == $past(wdata_in[6:4]))
    else $error("control bits do not follow the write");
  chk_wdog_sel: assert property (watchdog_reset_out |-> watchdog_select_out)
    else $error("watchdog expiry while plain timer selected");
  chk_ctrl_reset: assert property (
    $fell(reset_in) |-> watchdog_select_out && !wake_timer_enable_out
    && !rc_watchdog_mode_enable_out)
    else $error("control bits not at reset value");
endmodule

bind bitmr_top bitmr_chk i_bitmr_chk (.clk_in(clk_in), .reset_in(reset_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .stop_instruction_in(stop_instruction_in),
  .interval_overflow_out(interval_overflow_out), .watchdog_reset_out(watchdog_reset_out),
  .wake_tick_out(wake_tick_out), .power_mode_out(power_mode_out),
  .wake_timer_enable_out(wake_timer_enable_out),
  .rc_watchdog_mode_enable_out(rc_watchdog_mode_enable_out),
  .watchdog_select_out(watchdog_select_out));

// [testbench/bitmr_top_tb.sv]
`timescale 1ns/1ps
`include "bitmr_regs.svh"
module bitmr_top_tb;
  import bitmr_pkg::*;
  // ================================================================
  // Stimulus and observed signals
  // ================================================================
  logic           clk_in = 1'b0;
  logic           reset_in = 1'b1;
  logic [7:0]     addr_in = 8'h00;
  bitmr_byte_type wdata_in = 8'h00;
  logic           wr_in = 1'b0;
  logic           rd_in = 1'b0;
  logic           stop_instruction_in = 1'b0;
  logic           wake_event_in = 1'b0;
  bitmr_byte_type rdata_out;
  bitmr_mode_type power_mode_out;
  logic           irq_out, interval_overflow_out, watchdog_reset_out, wake_tick_out;
  logic           wake_timer_enable_out, rc_watchdog_mode_enable_out, watchdog_select_out;
  int             err_count = 0;
  int             n_compared = 0;
  int             cycles = 0;

  always #2 clk_in = ~clk_in;

  bitmr_top i_bitmr_top (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .stop_instruction_in(stop_instruction_in), .wake_event_in(wake_event_in),
    .irq_out(irq_out), .interval_overflow_out(interval_overflow_out),
    .watchdog_reset_out(watchdog_reset_out), .wake_tick_out(wake_tick_out),
    .power_mode_out(power_mode_out), .wake_timer_enable_out(wake_timer_enable_out),
    .rc_watchdog_mode_enable_out(rc_watchdog_mode_enable_out),
    .watchdog_select_out(watchdog_select_out));

  // ================================================================
  // Bus and compare helpers
  // ================================================================
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe, so sample just past that edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Bounded wait for a pulse, polled just after each edge
  task automatic wait_pulse(input int which, input int limit);
    for (int i = 0; i < limit; i++) begin
      @(posedge clk_in);
      #1;
      if ((which == 0 && interval_overflow_out === 1'b1) || (which == 1 && irq_out === 1'b1)
          || (which == 2 && wake_tick_out === 1'b1) || (which == 3 && watchdog_reset_out === 1'b1))
        return;
    end
  endtask

  // ================================================================
  // Scenarios
  // ================================================================
  task automatic t_reset;
    logic [7:0] d;
    rd_reg(`BITMR_ADDR_COUNT_CTRL, d);
    check("count after reset", 8'h00, d);
    check("control bits", 8'h01, {wake_timer_enable_out, rc_watchdog_mode_enable_out,
      watchdog_select_out});
    check("mode", 8'h01, {4'h0, power_mode_out});
    rd_reg(8'h10, d);
    check("unmapped read", 8'h00, d);
    $display("test reset done");
  endtask

  // Any window of 4*ratio clocks holds exactly four ticks
  task automatic t_rates;
    logic [7:0] a, b;
    for (int s = 0; s < 8; s++) begin
      wr_reg(`BITMR_ADDR_COUNT_CTRL, 8'h10 | s[7:0]);
      rd_reg(`BITMR_ADDR_COUNT_CTRL, a);
      repeat ((32 << s) - 2) @(posedge clk_in);
      rd_reg(`BITMR_ADDR_COUNT_CTRL, b);
      check("ticks per window", 8'h04, b - a);
    end
    $display("test rates done");
  endtask

  // Fastest ratio, so a wrap comes within 2048 clocks
  task automatic t_overflow;
    logic [7:0] d;
    wr_reg(`BITMR_ADDR_COUNT_CTRL, 8'h10);
    wait_pulse(0, 2100);
    check("overflow pulse", 8'h01, {7'h00, interval_overflow_out});
    rd_reg(`BITMR_ADDR_STATUS, d);
    check("status overflow", 8'h01, d & 8'h01);
    check("irq masked", 8'h00, {7'h00, irq_out});
    wr_reg(`BITMR_ADDR_MASK, 8'h01);
    wait_pulse(1, 3);
    check("irq unmasked", 8'h01, {7'h00, irq_out});
    wr_reg(`BITMR_ADDR_STATUS, 8'h01);
    rd_reg(`BITMR_ADDR_STATUS, d);
    check("status cleared", 8'h00, d & 8'h01);
    check("irq after clear", 8'h00, {7'h00, irq_out});
    wr_reg(`BITMR_ADDR_MASK, 8'h00);
    $display("test overflow done");
  endtask

  task automatic t_clear;
    logic [7:0] d;
    wr_reg(`BITMR_ADDR_COUNT_CTRL, 8'h18);
    rd_reg(`BITMR_ADDR_COUNT_CTRL, d);
    check("count after clear", 8'h00, d);
    // Counting restarts after the two-clock hold; 64 edges at ratio 8 give 8 ticks
    repeat (63) @(posedge clk_in);
    rd_reg(`BITMR_ADDR_COUNT_CTRL, d);
    check("count resumed", 8'h08, d);
    $display("test clear done");
  endtask

  task automatic t_stop(input logic [7:0] ctl, input bitmr_mode_type m, input logic runs);
    logic [7:0] a, b;
    wr_reg(`BITMR_ADDR_COUNT_CTRL, ctl);
    @(posedge clk_in);
    stop_instruction_in <= 1'b1;
    @(posedge clk_in);
    stop_instruction_in <= 1'b0;
    #1 check("stop mode", {4'h0, m}, {4'h0, power_mode_out});
    rd_reg(`BITMR_ADDR_COUNT_CTRL, a);
    repeat (62) @(posedge clk_in);
    rd_reg(`BITMR_ADDR_COUNT_CTRL, b);
    check("count moves", {7'h00, runs}, {7'h00, b != a});
    wait_pulse(2, 2100);
    check("long tap pulse", 8'h01, {7'h00, wake_tick_out});
    @(posedge clk_in);
    wake_event_in <= 1'b1;
    @(posedge clk_in);
    wake_event_in <= 1'b0;
    #1 check("back to run", {4'h0, BITMR_RUN}, {4'h0, power_mode_out});
    $display("test stop %h done", ctl);
  endtask

  // Limit of one makes the 7-bit timer expire within a few wraps
  task automatic t_watchdog;
    logic [7:0] d;
    wr_reg(`BITMR_ADDR_COUNT_CTRL, 8'h00);
    wr_reg(`BITMR_ADDR_STATUS, 8'h03);
    wr_reg(`BITMR_ADDR_MASK, 8'h02);
    wr_reg(`BITMR_ADDR_WATCHDOG, 8'h01);
    wait_pulse(1, 6500);
    rd_reg(`BITMR_ADDR_STATUS, d);
    check("plain timer match", 8'h02, d & 8'h02);
    // The match restarted the seven-bit count a few clocks ago
    rd_reg(`BITMR_ADDR_WATCHDOG, d);
    check("seven-bit count", 8'h00, d);
    wr_reg(`BITMR_ADDR_MASK, 8'h00);
    wr_reg(`BITMR_ADDR_COUNT_CTRL, 8'h10);
    wr_reg(`BITMR_ADDR_WATCHDOG, 8'h01);
    wait_pulse(3, 6500);
    check("watchdog expiry", 8'h01, {7'h00, watchdog_reset_out});
    $display("test watchdog done");
  endtask

  // ================================================================
  // Run control
  // ================================================================
  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Ceiling well above the expected run length
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      $display("timeout reached");
      tally_and_finish();
    end
  end

  initial begin
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_rates();
    t_overflow();
    t_clear();
    t_stop(8'h50, BITMR_WAKE_TIMER, 1'b0);
    t_stop(8'h30, BITMR_RC_WDT, 1'b1);
    t_stop(8'h10, BITMR_STOP, 1'b0);
    t_watchdog();
    tally_and_finish();
  end
endmodule
